// ==== src/serial_rx_pkg.sv ====
// Package of constants and types for the rate divider and synchronous slave receiver
// Summary of operation
// - Bit rate is clock over factor times n+1
// - Slave mode receives continuously, never idle
// - Single-receive enable ignored in slave mode
// - Reception continues during sleep, word transferred
// - Completed character in sleep raises wake interrupt
// - Ninth-bit enable selects 9-bit characters
// - Ninth received bit shown in status register
// - Complete character sets flag and interrupt
// - Low eight bits read through receive FIFO
// - Overrun cleared by continuous or port disable
package serial_rx_pkg;
	// Register addresses (index on the plain register port)
	localparam logic [2:0] ADDR_RATE_CTRL   = 3'h0;
	localparam logic [2:0] ADDR_RX_STATUS   = 3'h1;
	localparam logic [2:0] ADDR_DIV_LOW     = 3'h2;
	localparam logic [2:0] ADDR_DIV_HIGH    = 3'h3;
	localparam logic [2:0] ADDR_TX_STATUS   = 3'h4;
	localparam logic [2:0] ADDR_RX_DATA     = 3'h5;
	localparam logic [2:0] ADDR_IRQ_STATUS  = 3'h6;
	localparam logic [2:0] ADDR_IRQ_MASK    = 3'h7;
	// Field positions
	localparam int BIT_WIDE_DIV    = 3;  // Rate control
	localparam int BIT_PORT_EN     = 7;  // Receive status control
	localparam int BIT_NINTH_EN    = 6;
	localparam int BIT_SINGLE_EN   = 5;
	localparam int BIT_CONT_EN     = 4;
	localparam int BIT_OVERRUN     = 1;
	localparam int BIT_NINTH_DATA  = 0;
	localparam int BIT_CLK_MASTER  = 7;  // Transmit status control
	localparam int BIT_SYNC_MODE   = 4;
	localparam int BIT_HIGH_SPEED  = 2;
	localparam int IRQ_RX_DONE     = 0;  // Interrupt status bits
	localparam int IRQ_OVERRUN     = 1;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_IRQ  = 2'h0;
	// Divider factors
	localparam logic [6:0] FACTOR_64 = 7'h40;
	localparam logic [6:0] FACTOR_16 = 7'h10;
	localparam logic [6:0] FACTOR_4  = 7'h04;
	// Receive FIFO depth
	localparam int FIFO_DEPTH = 2;
	// Register write/read request
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;
	// One received character
	typedef struct packed {
		logic       ninth;
		logic [7:0] low;
	} rx_char_t;
	// Receiver shift states
	typedef enum logic [1:0] {
		RX_OFF   = 2'b00,
		RX_SHIFT = 2'b01
	} rx_state_t;
endpackage

// ==== src/rx_fifo_mem.sv ====
// Small receive FIFO memory with registered read data
module rx_fifo_mem #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Write port
	input  wire logic             wrEn,
	input  wire logic [WIDTH-1:0] wrData,
	input  wire logic [0:0]       wrAddr,
	// Read port
	input  wire logic [0:0]       rdAddr,
	output logic      [WIDTH-1:0] rdData
);
	// One pointer bit addresses exactly two entries
	if (DEPTH != 2 || WIDTH < 1) begin : g_size_check
		$error("rx_fifo_mem supports depth 2 only");
	end
	logic [WIDTH-1:0] mem [DEPTH];  // Storage entries
	// Write storage and register read word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
			rdData <= '0;
		end else begin
			if (wrEn) begin
				mem[wrAddr] <= wrData;
			end
			rdData <= (wrEn && wrAddr == rdAddr) ? wrData : mem[rdAddr];
		end
	end
endmodule

// ==== src/serial_sync_rx.sv ====
// Rate divider and synchronous slave receiver with register port and interrupt
//
// Design decisions made here: the strobed register port and the placing of the registers.
module serial_sync_rx (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Register port
	input  wire logic [2:0] regAddr,
	input  wire logic [7:0] regWdata,
	input  wire logic       regWr,
	input  wire logic       regRd,
	output logic      [7:0] regRdata,
	// Shift pins from the external master
	input  wire logic       shiftClockPin,
	input  wire logic       shiftDataPin,
	// Power state and interrupt
	input  wire logic       sleepMode,
	output logic            irq,
	output logic            wakeUp,
	output logic            rateTick
);
	// Bundle the register port into one request
	serial_rx_pkg::reg_req_t req;      // Bundled request
	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

	// Software registers
	logic [7:0] rateCtrl, next_rateCtrl;   // Rate control
	logic [7:0] rxCtrl, next_rxCtrl;       // Receive control bits (writable)
	logic [7:0] divLow, next_divLow;       // Divider low byte
	logic [7:0] divHigh, next_divHigh;     // Divider high byte
	logic [7:0] txCtrl, next_txCtrl;       // Transmit status control
	logic [1:0] irqStat, next_irqStat;     // Sticky events
	logic [1:0] irqMask, next_irqMask;     // Event masks
	logic [7:0] rdData, next_rdData;       // Read data register
	// Receiver state
	serial_rx_pkg::rx_state_t state, next_state;
	logic [8:0] shiftReg, next_shiftReg;   // Receive shift register
	logic [3:0] bitCnt, next_bitCnt;       // Bits received
	logic       ckPrev, next_ckPrev;       // Last shift clock level
	logic       overrun, next_overrun;     // Overrun error flag
	// FIFO state
	logic [0:0] wrPtr, next_wrPtr;
	logic [0:0] rdPtr, next_rdPtr;
	logic [1:0] count, next_count;
	serial_rx_pkg::rx_char_t headChar;     // Oldest character
	// Divider state
	logic [21:0] divCnt, next_divCnt;
	logic        tick, next_tick;

	// Decoded control fields
	logic portEn;     // Serial port enable
	logic syncMode;   // Clocked mode
	logic ninthEn;    // Ninth-bit receive enable
	logic wideDiv;    // 16-bit divider
	logic highSpeed;  // High-speed divider
	logic slaveMode;  // Clocked slave selected
	logic rxActive;   // Receiver running
	assign portEn    = rxCtrl[serial_rx_pkg::BIT_PORT_EN];
	assign syncMode  = txCtrl[serial_rx_pkg::BIT_SYNC_MODE];
	assign ninthEn   = rxCtrl[serial_rx_pkg::BIT_NINTH_EN];
	assign wideDiv   = rateCtrl[serial_rx_pkg::BIT_WIDE_DIV];
	assign highSpeed = txCtrl[serial_rx_pkg::BIT_HIGH_SPEED];
	// Slave needs clocked mode with external clock source
	assign slaveMode = portEn && syncMode && !txCtrl[serial_rx_pkg::BIT_CLK_MASTER];
	// Continuous receive treated as set, single enable unused
	assign rxActive  = slaveMode;

	// Divider factor selection
	logic [6:0]  factor;
	logic [15:0] divN;
	logic [21:0] period;
	always_comb begin
		divN = wideDiv ? {divHigh, divLow} : {8'h00, divLow};
		// Clocked mode ignores the high-speed bit
		if (syncMode) begin
			factor = serial_rx_pkg::FACTOR_4;
		end else if (!highSpeed) begin
			factor = wideDiv ? serial_rx_pkg::FACTOR_16 : serial_rx_pkg::FACTOR_64;
		end else begin
			factor = wideDiv ? serial_rx_pkg::FACTOR_4 : serial_rx_pkg::FACTOR_16;
		end
		// Tick every factor times n plus one clocks
		period = 22'(factor) * (22'(divN) + 22'h00_0001);
	end

	// Rate counter next state
	always_comb begin
		next_divCnt = divCnt;
		next_tick   = 1'b0;
		// Divider held cleared while the port is off
		if (!portEn) begin
			next_divCnt = '0;
		end else if (divCnt + 22'h00_0001 >= period) begin
			next_divCnt = '0;
			next_tick   = 1'b1;
		end else begin
			// Count toward the period
			next_divCnt = divCnt + 22'h00_0001;
		end
	end

	// Edge of external shift clock
	logic ckRise;
	assign ckRise = shiftClockPin && !ckPrev;

	// FIFO storage
	logic       pushEn;    // Store a completed character
	logic       popEn;     // Data read removes the head
	logic [8:0] pushData;  // Character to store
	// Read address is the next pointer, so head data are ready
	rx_fifo_mem #(.WIDTH(9), .DEPTH(serial_rx_pkg::FIFO_DEPTH)) u_mem (
		.clk    (clk),
		.rst_n  (rst_n),
		.wrEn   (pushEn),
		.wrData (pushData),
		.wrAddr (wrPtr),
		.rdAddr (next_rdPtr),
		.rdData (headChar)
	);

	// Receiver, FIFO and flag next state
	logic charDone;  // Character completed this cycle
	always_comb begin
		next_state    = state;
		next_shiftReg = shiftReg;
		next_bitCnt   = bitCnt;
		next_ckPrev   = shiftClockPin;
		next_overrun  = overrun;
		next_wrPtr    = wrPtr;
		next_rdPtr    = rdPtr;
		next_count    = count;
		charDone      = 1'b0;
		pushEn        = 1'b0;
		pushData      = shiftReg;
		// Data read pops only a non-empty FIFO
		popEn         = req.rd && req.addr == serial_rx_pkg::ADDR_RX_DATA && count != 2'h0;
		case (state)
			// Waiting for the slave path to be selected
			serial_rx_pkg::RX_OFF: begin
				next_bitCnt = '0;
				if (rxActive) begin
					next_state = serial_rx_pkg::RX_SHIFT;
				end
			end
			// Count bits on each rising shift clock
			serial_rx_pkg::RX_SHIFT: begin
				if (!rxActive) begin
					next_state = serial_rx_pkg::RX_OFF;
				end else if (ckRise) begin
					// Shift in LSB first, keep going during sleep
					next_shiftReg = {shiftDataPin, shiftReg[8:1]};
					if (bitCnt == (ninthEn ? 4'h8 : 4'h7)) begin
						// Last bit of the character
						charDone    = 1'b1;
						next_bitCnt = '0;
						pushData    = ninthEn ? {shiftDataPin, shiftReg[8:1]}
						                      : {1'b0, shiftDataPin, shiftReg[8:2]};
					end else begin
						// More bits to come
						next_bitCnt = bitCnt + 4'h1;
					end
				end
			end
			// Unused code recovers to off
			default: next_state = serial_rx_pkg::RX_OFF;
		endcase
		// Full FIFO loses the new character
		if (charDone) begin
			if (count == 2'(serial_rx_pkg::FIFO_DEPTH)) begin
				next_overrun = 1'b1;
			end else begin
				pushEn = 1'b1;
			end
		end
		if (pushEn) begin
			next_wrPtr = wrPtr + 1'b1;
		end
		if (popEn) begin
			next_rdPtr = rdPtr + 1'b1;
		end
		// Occupancy follows pushes and pops
		next_count = count + {1'b0, pushEn} - {1'b0, popEn};
		// Disable or port off clears overrun
		if (!portEn || !rxCtrl[serial_rx_pkg::BIT_CONT_EN]) begin
			next_overrun = 1'b0;
		end
		// Port disable resets the whole receive unit
		if (!portEn) begin
			next_shiftReg = '0;
			next_bitCnt   = '0;
			next_wrPtr    = '0;
			next_rdPtr    = '0;
			next_count    = '0;
		end
	end

	// Register writes and sticky events
	always_comb begin
		next_rateCtrl = rateCtrl;
		next_rxCtrl   = rxCtrl;
		next_divLow   = divLow;
		next_divHigh  = divHigh;
		next_txCtrl   = txCtrl;
		next_irqMask  = irqMask;
		next_irqStat  = irqStat;
		// Software writes land on the next edge
		if (req.wr) begin
			case (req.addr)
				serial_rx_pkg::ADDR_RATE_CTRL: next_rateCtrl = req.wdata;
				serial_rx_pkg::ADDR_RX_STATUS: next_rxCtrl   = req.wdata;
				serial_rx_pkg::ADDR_DIV_LOW:   next_divLow   = req.wdata;
				serial_rx_pkg::ADDR_DIV_HIGH:  next_divHigh  = req.wdata;
				serial_rx_pkg::ADDR_TX_STATUS: next_txCtrl   = req.wdata;
				serial_rx_pkg::ADDR_IRQ_STATUS: next_irqStat = irqStat & ~req.wdata[1:0];
				serial_rx_pkg::ADDR_IRQ_MASK:  next_irqMask = req.wdata[1:0];
				default: ;
			endcase
		end
		// Set wins over write-one clear
		if (pushEn) begin
			next_irqStat[serial_rx_pkg::IRQ_RX_DONE] = 1'b1;
		end
		// Overrun event on the rising edge of the flag
		if (next_overrun && !overrun) begin
			next_irqStat[serial_rx_pkg::IRQ_OVERRUN] = 1'b1;
		end
	end

	// Read data mux, one cycle later
	always_comb begin
		next_rdData = 8'h00;
		// Zero unless a read is in progress
		if (req.rd) begin
			case (req.addr)
				serial_rx_pkg::ADDR_RATE_CTRL: next_rdData = rateCtrl;
				serial_rx_pkg::ADDR_RX_STATUS: begin
					next_rdData = rxCtrl & 8'hFC;
					next_rdData[serial_rx_pkg::BIT_OVERRUN]    = overrun;
					next_rdData[serial_rx_pkg::BIT_NINTH_DATA] = headChar.ninth;
				end
				serial_rx_pkg::ADDR_DIV_LOW:    next_rdData = divLow;
				serial_rx_pkg::ADDR_DIV_HIGH:   next_rdData = divHigh;
				serial_rx_pkg::ADDR_TX_STATUS:  next_rdData = txCtrl;
				serial_rx_pkg::ADDR_RX_DATA:    next_rdData = headChar.low;
				serial_rx_pkg::ADDR_IRQ_STATUS: next_rdData = {6'h00, irqStat};
				serial_rx_pkg::ADDR_IRQ_MASK:   next_rdData = {6'h00, irqMask};
				default:                        next_rdData = 8'h00;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// Everything starts cleared
			rateCtrl <= serial_rx_pkg::RST_BYTE;
			rxCtrl   <= serial_rx_pkg::RST_BYTE;
			divLow   <= serial_rx_pkg::RST_BYTE;
			divHigh  <= serial_rx_pkg::RST_BYTE;
			txCtrl   <= serial_rx_pkg::RST_BYTE;
			irqStat  <= serial_rx_pkg::RST_IRQ;
			irqMask  <= serial_rx_pkg::RST_IRQ;
			rdData   <= serial_rx_pkg::RST_BYTE;
			state    <= serial_rx_pkg::RX_OFF;
			shiftReg <= '0;
			bitCnt   <= '0;
			ckPrev   <= 1'b0;
			overrun  <= 1'b0;
			wrPtr    <= '0;
			rdPtr    <= '0;
			count    <= '0;
			divCnt   <= '0;
			tick     <= 1'b0;
		end else begin
			// Take all next values
			rateCtrl <= next_rateCtrl;
			rxCtrl   <= next_rxCtrl;
			divLow   <= next_divLow;
			divHigh  <= next_divHigh;
			txCtrl   <= next_txCtrl;
			irqStat  <= next_irqStat;
			irqMask  <= next_irqMask;
			rdData   <= next_rdData;
			state    <= next_state;
			shiftReg <= next_shiftReg;
			bitCnt   <= next_bitCnt;
			ckPrev   <= next_ckPrev;
			overrun  <= next_overrun;
			wrPtr    <= next_wrPtr;
			rdPtr    <= next_rdPtr;
			count    <= next_count;
			divCnt <= next_divCnt;
			tick   <= next_tick;
		end
	end

	// Outputs
	assign regRdata = rdData;
	assign irq      = |(irqStat & irqMask);
	// Wake needs sleep and an unmasked completion
	assign wakeUp   = sleepMode && irq && irqMask[serial_rx_pkg::IRQ_RX_DONE]
	                  && irqStat[serial_rx_pkg::IRQ_RX_DONE];
	assign rateTick = tick;
endmodule

// ==== tb/serial_sync_rx_sva.sv ====
// Checker of register port, interrupt and rate tick
module serial_sync_rx_sva (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// Register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdata,
	// Power and events
	input wire logic       sleepMode,
	input wire logic       irq,
	input wire logic       wakeUp,
	input wire logic       rateTick
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic mWr;  // Mask write
	logic hWr;  // Divider high write
	logic hRd;  // Divider high read
	assign mWr = regWr && regAddr == serial_rx_pkg::ADDR_IRQ_MASK;
	assign hWr = regWr && regAddr == serial_rx_pkg::ADDR_DIV_HIGH;
	assign hRd = regRd && regAddr == serial_rx_pkg::ADDR_DIV_HIGH;
	// Read data only in the slot after a read
	rd_slot_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data out of slot");
	// Divider byte reads back as written
	div_back_a: assert property (hWr ##1 hRd |=> regRdata == $past(regWdata, 2))
		else $error("divider readback wrong");
	// Wake only with interrupt and sleep
	wake_irq_a: assert property (wakeUp |-> irq)
		else $error("wake without irq");
	wake_sleep_a: assert property (wakeUp |-> sleepMode || $past(sleepMode))
		else $error("wake while awake");
	// Rate tick spacing at least four clocks
	tick_gap_a: assert property (rateTick |=> !rateTick [*3])
		else $error("rate ticks too close");
	// Masking silences interrupt and wake
	mask_off_a: assert property (mWr && regWdata == 8'h00 |-> ##[1:2] !irq)
		else $error("irq with mask clear");
	mask_wake_a: assert property (mWr && !regWdata[0] |-> ##[1:2] !wakeUp)
		else $error("wake with mask clear");
	// Interrupt drops only after a write
	irq_fall_a: assert property ($fell(irq) |-> $past(regWr) || $past(regWr, 2))
		else $error("irq dropped by itself");
	// Main scenarios
	cover property (rateTick);
	cover property (wakeUp);
	cover property ($rose(irq));
endmodule

// ==== tb/serial_master_model.sv ====
// External shift master model driving clock and data
module serial_master_model (
	// Clock
	input  wire logic clk,
	// Shift pins
	output logic      sck,
	output logic      sdt
);
	timeunit 1ns;
	timeprecision 1ns;
	// Clock parked low between frames
	initial begin
		sck = 1'b0;
		sdt = 1'b1;
	end
	// Send n bits LSB first, hw clocks per half bit
	task automatic send(input logic [8:0] v, input int n, input int hw);
		for (int i = 0; i < n; i++) begin
			sdt <= v[i];
			repeat (hw) @(posedge clk);
			sck <= 1'b1;
			repeat (hw) @(posedge clk);
			sck <= 1'b0;
		end
		// Data no longer held after the frame
		sdt <= ~v[n-1];
		@(posedge clk);
	endtask
endmodule

// ==== tb/tb_top.sv ====
// Top bench for the rate divider and slave receiver
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// Design inputs
	logic       clk       = 1'b0;
	logic       rst_n     = 1'b0;
	logic [2:0] regAddr   = 3'h0;
	logic [7:0] regWdata  = 8'h00;
	logic       regWr     = 1'b0;
	logic       regRd     = 1'b0;
	logic       sleepMode = 1'b0;
	// Design outputs and pins
	logic [7:0] regRdata;
	logic       sck, sdt, irq, wakeUp, rateTick;
	logic [8:0] rv;  // Last read value
	int         numErrors = 0;
	int         numChecks = 0;
	int         cyc       = 0;
	// Modes: transmit control, rate control, factor
	localparam logic [7:0] TXM [6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h14, 8'h10};
	localparam logic [7:0] RCM [6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
	localparam int         FAC [6] = '{64, 16, 16, 4, 4, 4};
	// 25 MHz clock
	always #20 clk = ~clk;
	// Block under test and shift master
	serial_sync_rx DUT (.clk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.shiftClockPin(sck), .shiftDataPin(sdt), .sleepMode, .irq, .wakeUp, .rateTick);
	serial_master_model master (.clk, .sck, .sdt);
	// Compare and count
	task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		numChecks++;
		if (seen !== exp) begin
			numErrors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Wait k edges, then settle
	task automatic cy(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// One-cycle register write
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
	endtask
	// One-cycle register read, data in the next cycle
	task automatic rd(input logic [2:0] a);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 rv = {1'b0, regRdata};
	endtask
	// Cycles up to the next rate tick
	task automatic tick(output int n);
		n = 0;
		do begin
			cy(1);
			n++;
		end while (rateTick !== 1'b1 && n < 400);
	endtask
	// Tick period per mode with n = 2
	task automatic t_rate;
		int n;
		wr(serial_rx_pkg::ADDR_DIV_LOW, 8'h02);
		wr(serial_rx_pkg::ADDR_DIV_HIGH, 8'h5A);
		rd(serial_rx_pkg::ADDR_DIV_HIGH);
		chk("div high", rv, 9'h05A);
		wr(serial_rx_pkg::ADDR_DIV_HIGH, 8'h00);
		wr(serial_rx_pkg::ADDR_RX_STATUS, 8'h80);
		for (int i = 0; i < 6; i++) begin
			wr(serial_rx_pkg::ADDR_TX_STATUS, TXM[i]);
			wr(serial_rx_pkg::ADDR_RATE_CTRL, RCM[i]);
			tick(n);
			tick(n);
			chk("period", 9'(n), 9'(FAC[i] * 3));
		end
	endtask
	// 8-bit slave reception, continuous clear, single set
	task automatic t_rx8;
		wr(serial_rx_pkg::ADDR_TX_STATUS, 8'h10);
		wr(serial_rx_pkg::ADDR_RX_STATUS, 8'hA0);
		wr(serial_rx_pkg::ADDR_IRQ_MASK, 8'h01);
		master.send(9'h0A5, 8, 1);
		cy(3);
		chk("irq", 9'(irq), 9'h001);
		chk("awake", 9'(wakeUp), 9'h000);
		rd(serial_rx_pkg::ADDR_IRQ_STATUS);
		chk("done", rv, 9'h001);
		rd(serial_rx_pkg::ADDR_RX_DATA);
		chk("data", rv, 9'h0A5);
		wr(serial_rx_pkg::ADDR_IRQ_STATUS, 8'h01);
		cy(1);
		chk("irq", 9'(irq), 9'h000);
	endtask
	// 9-bit reception with slow master
	task automatic t_rx9;
		wr(serial_rx_pkg::ADDR_RX_STATUS, 8'hD0);
		master.send(9'h13C, 9, 3);
		cy(3);
		rd(serial_rx_pkg::ADDR_RX_STATUS);
		chk("ninth", rv, 9'h0D1);
		rd(serial_rx_pkg::ADDR_RX_DATA);
		chk("data", rv, 9'h03C);
		wr(serial_rx_pkg::ADDR_IRQ_STATUS, 8'h01);
	endtask
	// Reception and wake while asleep
	task automatic t_sleep;
		sleepMode <= 1'b1;
		master.send(9'h05A, 9, 1);
		cy(3);
		chk("wake", 9'(wakeUp), 9'h001);
		rd(serial_rx_pkg::ADDR_RX_DATA);
		chk("data", rv, 9'h05A);
		sleepMode <= 1'b0;
		wr(serial_rx_pkg::ADDR_IRQ_STATUS, 8'h01);
	endtask
	// Third character overruns, cleared by clearing continuous enable
	task automatic t_ovr;
		wr(serial_rx_pkg::ADDR_RX_STATUS, 8'h90);
		master.send(9'h011, 8, 1);
		master.send(9'h022, 8, 1);
		master.send(9'h033, 8, 1);
		cy(3);
		rd(serial_rx_pkg::ADDR_RX_STATUS);
		chk("overrun", rv, 9'h092);
		rd(serial_rx_pkg::ADDR_IRQ_STATUS);
		chk("events", rv, 9'h003);
		wr(serial_rx_pkg::ADDR_IRQ_MASK, 8'h00);
		wr(serial_rx_pkg::ADDR_RX_STATUS, 8'h80);
		cy(1);
		chk("irq", 9'(irq), 9'h000);
		rd(serial_rx_pkg::ADDR_RX_STATUS);
		chk("ovr clear", rv, 9'h080);
		rd(serial_rx_pkg::ADDR_RX_DATA);
		chk("data", rv, 9'h011);
		rd(serial_rx_pkg::ADDR_RX_DATA);
		chk("second", rv, 9'h022);
	endtask
	// Master clock source selected: no slave reception
	task automatic t_master;
		wr(serial_rx_pkg::ADDR_IRQ_STATUS, 8'h03);
		wr(serial_rx_pkg::ADDR_TX_STATUS, 8'h90);
		master.send(9'h0FF, 8, 1);
		cy(3);
		rd(serial_rx_pkg::ADDR_IRQ_STATUS);
		chk("no rx", rv, 9'h000);
	endtask
	// Verdict and end of run
	task automatic summarize;
		if (numErrors == 0 && numChecks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Run limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			numErrors++;
			summarize;
		end
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		cy(1);
		t_rate;
		t_rx8;
		t_rx9;
		t_sleep;
		t_ovr;
		t_master;
		summarize;
	end
endmodule
bind serial_sync_rx serial_sync_rx_sva chkr (.clk, .rst_n, .regAddr, .regWdata, .regWr,
	.regRd, .regRdata, .sleepMode, .irq, .wakeUp, .rateTick);
